// ---- rtl/dac_format_top.sv ----
// top: output word formatting, test patterns, power and mode selection
`timescale 1ns/100ps
`include "dac_consts.svh"
// **********
// Overview of operation
// - randomizer XORs every data bit above the LSB with the LSB.
// - alternate polarity inverts odd data bits one through fifteen.
// - randomizer and alternate polarity enable independently.
// - test patterns: all ones, all zeros, alternating, checkerboard over seventeen bits.
// - selected test pattern overrides all formatting.
// - output disable floats all outputs including flag and strobe.
// - nap channel two alone or both, never channel one alone.
// - parallel select high makes serial pins static mode inputs.
// - parallel chip select sets duty cycle stabilizer.
// - parallel serial clock picks full rate or DDR differential.
// - parallel data pin pair decodes power state.
// - transfer framed by select; only first sixteen clock edges sampled.
// - command word is flag, seven address bits, eight data bits.
// - low flag writes; high flag reads back without update.
// - serial data out is open drain, pulled low only.
// - reset bit clears all registers then self clears.
// - reset register at address zero, bit seven, write only.
// - power bits in address one bits one to zero.
// **********
module dac_format_top
	import dac_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic sample_valid,
	input wire logic [15:0] ch1_data,
	input wire logic ch1_ovr,
	input wire logic [15:0] ch2_data,
	input wire logic ch2_ovr,
	input wire logic port_style_select,
	input wire logic sel_n_pin,
	input wire logic sck_pin,
	input wire logic sdi_pin,
	input wire logic sdo_pin_in,
	output logic sdo_pin_out,
	output logic sdo_pin_oe,
	output logic [15:0] ch1_out,
	output logic ch1_overrange_flag,
	output logic [15:0] ch2_out,
	output logic ch2_overrange_flag,
	output logic sample_strobe_out,
	output logic outputs_oe,
	output logic dcs_enable,
	output logic lvds_ddr_mode,
	output logic ch1_nap,
	output logic ch2_nap,
	output logic device_sleep
);
	// **********
	// pin synchronisers
	// **********
	logic [4:0] sync1_r;
	logic [4:0] sync2_r;
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			// idle pin levels, so no false select edge follows reset
			sync1_r <= `DAC_SYNC_IDLE;
			sync2_r <= `DAC_SYNC_IDLE;
		end
		else
		begin
			sync1_r <= {port_style_select, sel_n_pin, sck_pin, sdi_pin, sdo_pin_in};
			sync2_r <= sync1_r;
		end
	end
	wire par_mode = sync2_r[4];
	wire sel_s = sync2_r[3];
	wire sck_s = sync2_r[2];
	wire sdi_s = sync2_r[1];
	wire sdo_s = sync2_r[0];

	// **********
	// serial configuration
	// **********
	logic [7:0] pwr_reg;
	logic [7:0] outmode_reg;
	logic [7:0] format_reg;
	logic port_sdo_oe;
	dac_serial_port u_port
	(
		.core_clk(core_clk),
		.reset(reset),
		.enable(~par_mode),
		.sel_n(sel_s),
		.sck(sck_s),
		.sdi(sdi_s),
		.sdo_oe(port_sdo_oe),
		.pwr_reg(pwr_reg),
		.outmode_reg(outmode_reg),
		.format_reg(format_reg),
		.timing_reg()
	);
	assign sdo_pin_out = 1'b0;
	assign sdo_pin_oe = port_sdo_oe & ~par_mode;

	// **********
	// configuration selection
	// **********
	// parallel pins as static levels
	dac_cfg_t cfg;
	wire [2:0] tp_code = format_reg[`DAC_TP_LSB +: 3];
	dac_cfg_t par_cfg;
	dac_cfg_t ser_cfg;
	assign par_cfg = '{dcs_on: sel_s, lvds_ddr: sck_s, outputs_off: 1'b0, randomize: 1'b0, alt_polarity: 1'b0,
		pattern: DAC_TP_OFF, power: dac_pwr_t'({sdi_s, sdo_s})};
	assign ser_cfg = '{dcs_on: 1'b0, lvds_ddr: outmode_reg[`DAC_BIT_LVDS], outputs_off: outmode_reg[`DAC_BIT_OUTOFF],
		randomize: format_reg[`DAC_BIT_RAND], alt_polarity: format_reg[`DAC_BIT_ALT], pattern: dac_tp_t'(tp_code),
		power: dac_pwr_t'(pwr_reg[1:0])};
	assign cfg = par_mode ? par_cfg : ser_cfg;

	// channel one naps only with two
	assign ch2_nap = (cfg.power == DAC_PWR_NAP2) | (cfg.power == DAC_PWR_NAPBOTH);
	assign ch1_nap = (cfg.power == DAC_PWR_NAPBOTH);
	assign device_sleep = (cfg.power == DAC_PWR_SLEEP);
	assign dcs_enable = cfg.dcs_on;
	assign lvds_ddr_mode = cfg.lvds_ddr;

	// **********
	// formatting
	// **********
	function automatic dac_word_t fmt(input dac_word_t w, input logic rnd, input logic alt);
		dac_word_t r;
		r = w;
		if (rnd)
			r.data[15:1] = w.data[15:1] ^ {15{w.data[0]}};
		if (alt)
			r.data = r.data ^ `DAC_ODD_MASK;
		fmt = r;
	endfunction

	logic phase_r;
	always_ff @(posedge core_clk)
	begin
		if (reset)
			phase_r <= 1'b0;
		else if (sample_valid)
			phase_r <= ~phase_r;
	end

	logic [16:0] pat;
	always_comb
	begin
		unique case (cfg.pattern)
			DAC_TP_ONES: pat = `DAC_ALL_ONES;
			DAC_TP_ZEROS: pat = 17'h00000;
			DAC_TP_ALT: pat = phase_r ? `DAC_ALL_ONES : 17'h00000;
			DAC_TP_CHECK: pat = phase_r ? ~`DAC_CHECK_A : `DAC_CHECK_A;
			default: pat = 17'h00000;
		endcase
	end
	wire tp_on = (cfg.pattern != DAC_TP_OFF);

	wire dac_word_t f1 = fmt('{ovr: ch1_ovr, data: ch1_data}, cfg.randomize, cfg.alt_polarity);
	wire dac_word_t f2 = fmt('{ovr: ch2_ovr, data: ch2_data}, cfg.randomize, cfg.alt_polarity);
	wire dac_word_t o1 = tp_on ? dac_word_t'(pat) : f1;
	wire dac_word_t o2 = tp_on ? dac_word_t'(pat) : f2;

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			{ch1_overrange_flag, ch1_out} <= 17'h00000;
			{ch2_overrange_flag, ch2_out} <= 17'h00000;
			sample_strobe_out <= 1'b0;
		end
		else
		begin
			sample_strobe_out <= sample_valid;
			if (sample_valid)
			begin
				{ch1_overrange_flag, ch1_out} <= o1;
				{ch2_overrange_flag, ch2_out} <= o2;
			end
		end
	end
	assign outputs_oe = ~cfg.outputs_off;

	// **********
	// checks
	// **********
	chk_rand_lsb_kept:
	assert property (@(posedge core_clk) disable iff (reset) (sample_valid && !tp_on && cfg.randomize
		&& !cfg.alt_polarity) |=> (ch1_out == {$past(ch1_data[15:1]) ^ {15{$past(ch1_data[0])}}, $past(ch1_data[0])}))
	else $error("randomized word wrong");
	chk_alt_odd_bits:
	assert property (@(posedge core_clk) disable iff (reset) (sample_valid && !tp_on && !cfg.randomize
		&& cfg.alt_polarity) |=> (ch2_out == ($past(ch2_data) ^ 16'hAAAA)))
	else $error("alternate polarity wrong");
	chk_pattern_wins:
	assert property (@(posedge core_clk) disable iff (reset) (sample_valid && cfg.pattern == DAC_TP_ONES)
		|=> (ch1_out == 16'hFFFF) && ch1_overrange_flag)
	else $error("pattern not forced");
	chk_check_toggles:
	assert property (@(posedge core_clk) disable iff (reset) (sample_valid && cfg.pattern == DAC_TP_CHECK
		&& $stable(cfg.pattern)) |=> ({ch1_overrange_flag, ch1_out} == ($past(phase_r) ? 17'h0AAAA : 17'h15555)))
	else $error("checkerboard phase wrong");
	chk_nap_order:
	assert property (@(posedge core_clk) disable iff (reset) ch1_nap |-> ch2_nap)
	else $error("channel one napping alone");
	chk_outputs_off:
	assert property (@(posedge core_clk) disable iff (reset) (!par_mode && outmode_reg[`DAC_BIT_OUTOFF]) |-> !outputs_oe)
	else $error("outputs not disabled");
	chk_par_power:
	assert property (@(posedge core_clk) disable iff (reset) (par_mode && sdi_s && sdo_s) |-> device_sleep)
	else $error("parallel sleep not decoded");
	chk_par_dcs:
	assert property (@(posedge core_clk) disable iff (reset) par_mode |-> (dcs_enable == sel_s))
	else $error("stabilizer not following pin");
endmodule

// ---- rtl/dac_consts.svh ----
// constants for the dual converter output formatter and configuration port
`ifndef DAC_CONSTS_SVH
`define DAC_CONSTS_SVH
`define DAC_ADDR_RESET 7'h00
`define DAC_ADDR_PWR 7'h01
`define DAC_ADDR_TIMING 7'h02
`define DAC_ADDR_OUTMODE 7'h03
`define DAC_ADDR_FORMAT 7'h04
`define DAC_RESET_BIT 7
`define DAC_CMD_BITS 5'h10
`define DAC_RD_EDGE 5'h08
// synchroniser reset: select high, read-back line pulled up
`define DAC_SYNC_IDLE 5'h09
`define DAC_REG_RESET 8'h00
`define DAC_BIT_DCS 0
`define DAC_BIT_OUTOFF 2
`define DAC_BIT_LVDS 0
`define DAC_BIT_RAND 1
`define DAC_BIT_ALT 2
`define DAC_TP_LSB 3
`define DAC_ODD_MASK 16'hAAAA
`define DAC_CHECK_A 17'h15555
`define DAC_ALL_ONES 17'h1FFFF
`endif

// ---- rtl/dac_pkg.sv ----
// types for the dual converter output formatter
package dac_pkg;
	typedef enum logic [1:0]
	{
		DAC_PWR_NORMAL = 2'b00,
		DAC_PWR_NAP2 = 2'b01,
		DAC_PWR_NAPBOTH = 2'b10,
		DAC_PWR_SLEEP = 2'b11
	} dac_pwr_t;
	typedef enum logic [2:0]
	{
		DAC_TP_OFF = 3'b000,
		DAC_TP_ONES = 3'b001,
		DAC_TP_ZEROS = 3'b010,
		DAC_TP_ALT = 3'b011,
		DAC_TP_CHECK = 3'b100
	} dac_tp_t;
	typedef struct packed
	{
		logic ovr;
		logic [15:0] data;
	} dac_word_t;
	typedef struct packed
	{
		logic dcs_on;
		logic lvds_ddr;
		logic outputs_off;
		logic randomize;
		logic alt_polarity;
		dac_tp_t pattern;
		dac_pwr_t power;
	} dac_cfg_t;
endpackage

// ---- rtl/dac_serial_port.sv ----
// serial configuration port: command shifter, register file, open-drain read-back
`timescale 1ns/100ps
`include "dac_consts.svh"
module dac_serial_port
	import dac_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic enable,
	input wire logic sel_n,
	input wire logic sck,
	input wire logic sdi,
	output logic sdo_oe,
	output logic [7:0] pwr_reg,
	output logic [7:0] outmode_reg,
	output logic [7:0] format_reg,
	output logic [7:0] timing_reg
);
	logic [4:0] cnt_r;
	logic [15:0] shift_r;
	logic [7:0] rd_r;
	logic sck_d_r;
	logic sel_d_r;
	logic [7:0] regs_r [0:3];
	logic [7:0] regs_nxt [0:3];
	wire rise = sck & ~sck_d_r;
	wire fall = ~sck & sck_d_r;
	wire active = enable & ~sel_n;
	wire done = enable & sel_n & ~sel_d_r;
	wire [15:0] cmd = shift_r;
	wire is_write = ~cmd[15];
	wire [6:0] addr = cmd[14:8];
	wire soft_reset = done & is_write & (cnt_r == `DAC_CMD_BITS) & (addr == `DAC_ADDR_RESET)
		& cmd[`DAC_RESET_BIT];

	// **********
	// register read decode
	// **********
	function automatic logic [7:0] rd_sel(input logic [6:0] a, input logic [7:0] r0, input logic [7:0] r1,
		input logic [7:0] r2, input logic [7:0] r3);
		// unmapped and reset addresses read back as zeros
		rd_sel = (a == `DAC_ADDR_PWR) ? r0 : (a == `DAC_ADDR_TIMING) ? r1
			: (a == `DAC_ADDR_OUTMODE) ? r2 : (a == `DAC_ADDR_FORMAT) ? r3 : 8'h00;
	endfunction

	always_comb
	begin
		for (int i = 0; i < 4; i++)
			regs_nxt[i] = regs_r[i];
		if (done & is_write & (cnt_r == `DAC_CMD_BITS) & (addr >= `DAC_ADDR_PWR) & (addr <= `DAC_ADDR_FORMAT))
			// addresses one to four fold onto slots zero to three
			regs_nxt[addr[1:0] - 2'h1] = cmd[7:0];
	end

	always_ff @(posedge core_clk)
	begin
		sck_d_r <= sck;
		sel_d_r <= sel_n;
		if (reset | soft_reset)
		begin
			for (int i = 0; i < 4; i++)
				regs_r[i] <= `DAC_REG_RESET;
		end
		else
		begin
			for (int i = 0; i < 4; i++)
				regs_r[i] <= regs_nxt[i];
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (reset | ~active)
		begin
			cnt_r <= 5'h00;
			if (reset)
				shift_r <= 16'h0000;
		end
		else if (rise & (cnt_r < `DAC_CMD_BITS))
		begin
			cnt_r <= cnt_r + 5'h01;
			shift_r <= {shift_r[14:0], sdi};
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (reset | ~active)
			rd_r <= 8'hFF;
		else if (fall & (cnt_r == `DAC_RD_EDGE) & shift_r[7])
			rd_r <= rd_sel({shift_r[6:0]}, regs_r[0], regs_r[1], regs_r[2], regs_r[3]);
		else if (fall & (cnt_r > `DAC_RD_EDGE))
			rd_r <= {rd_r[6:0], 1'b1};
	end

	assign sdo_oe = active & ~rd_r[7] & (cnt_r >= `DAC_RD_EDGE);
	// addr 01..04 map to slots 0..3 with slot 1 the timing register
	assign pwr_reg = regs_r[0];
	assign timing_reg = regs_r[1];
	assign outmode_reg = regs_r[2];
	assign format_reg = regs_r[3];

	chk_soft_reset_clears:
	assert property (@(posedge core_clk) disable iff (reset) soft_reset |=> (pwr_reg == 8'h00)
		&& (format_reg == 8'h00))
	else $error("soft reset did not clear");
	chk_count_limit:
	assert property (@(posedge core_clk) disable iff (reset) cnt_r <= `DAC_CMD_BITS)
	else $error("edge count beyond sixteen");
	chk_read_no_write:
	assert property (@(posedge core_clk) disable iff (reset) (done & cmd[15]) |=> $stable(pwr_reg))
	else $error("read changed register");
	chk_sdo_only_low:
	assert property (@(posedge core_clk) disable iff (reset) sdo_oe |-> (active && cnt_r >= `DAC_RD_EDGE))
	else $error("sdo driven outside read");
endmodule

// ---- tb/dac_host_model.sv ----
// host side model: serial configuration master and pulled-up read-back line
`timescale 1ns/100ps
module dac_host_model
(
	input wire logic par_mode,
	input wire logic sdo_oe,
	input wire logic sdo_out,
	output logic sel_n,
	output logic sck,
	output logic sdi,
	output logic sdo_in
);
	logic par_sdo;
	assign sdo_in = par_mode ? par_sdo : (sdo_oe ? sdo_out : 1'b1);
	initial
	begin
		sel_n = 1'b1;
		sck = 1'b0;
		sdi = 1'b0;
		par_sdo = 1'b0;
	end
	task automatic pins(input logic [3:0] v);
		{sel_n, sck, sdi, par_sdo} = v;
	endtask
	task automatic xfer(input logic [15:0] cmd, input int edges, output logic [7:0] rd);
		rd = 8'h00;
		#7 sel_n = 1'b0;
		for (int i = 0; i < edges; i++)
		begin
			sdi = (i < 16) ? cmd[15 - i] : ~sdi;
			#32;
			if (i >= 8 && i < 16)
				rd = {rd[6:0], sdo_in};
			sck = 1'b1;
			#32 sck = 1'b0;
		end
		#32 sel_n = 1'b1;
		sdi = ~sdi;
		// sync and landing take a few core cycles
		#40;
	endtask
endmodule

// ---- tb/test_dac_format_top.sv ----
// self-checking bench for the output formatter and configuration port
`timescale 1ns/100ps
module test_dac_format_top;
	logic core_clk, reset, sample_valid, ch1_ovr, ch2_ovr, port_style_select;
	logic [15:0] ch1_data, ch2_data, ch1_out, ch2_out;
	logic sel_n, sck, sdi, sdo_in, sdo_out, sdo_oe, ch1_of, ch2_of, strobe, outputs_oe;
	logic dcs_enable, lvds_ddr_mode, ch1_nap, ch2_nap, device_sleep;
	logic [7:0] rd;
	logic [16:0] w1, w2, a, exp, prev;
	int fails, total_checks;
	dac_format_top dac_format_top_i (.core_clk(core_clk), .reset(reset), .sample_valid(sample_valid),
		.ch1_data(ch1_data), .ch1_ovr(ch1_ovr), .ch2_data(ch2_data), .ch2_ovr(ch2_ovr),
		.port_style_select(port_style_select), .sel_n_pin(sel_n), .sck_pin(sck), .sdi_pin(sdi),
		.sdo_pin_in(sdo_in), .sdo_pin_out(sdo_out), .sdo_pin_oe(sdo_oe), .ch1_out(ch1_out),
		.ch1_overrange_flag(ch1_of), .ch2_out(ch2_out), .ch2_overrange_flag(ch2_of),
		.sample_strobe_out(strobe), .outputs_oe(outputs_oe), .dcs_enable(dcs_enable),
		.lvds_ddr_mode(lvds_ddr_mode), .ch1_nap(ch1_nap), .ch2_nap(ch2_nap), .device_sleep(device_sleep));
	dac_host_model dac_host_model_i (.par_mode(port_style_select), .sdo_oe(sdo_oe), .sdo_out(sdo_out),
		.sel_n(sel_n), .sck(sck), .sdi(sdi), .sdo_in(sdo_in));
	initial
	begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	task automatic chk(input logic [16:0] got, input logic [16:0] e);
		total_checks++;
		if (got !== e)
		begin
			fails++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, e);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic cfg(input logic [6:0] ad, input logic [7:0] d);
		dac_host_model_i.xfer({1'b0, ad, d}, 16, rd);
		@(posedge core_clk) #1;
	endtask
	task automatic rdchk(input logic [6:0] ad, input logic [7:0] e);
		dac_host_model_i.xfer({1'b1, ad, 8'hFF}, 16, rd);
		chk(rd, e);
	endtask
	task automatic sample(input logic [16:0] x, input logic [16:0] y);
		sample_valid = 1'b1;
		{ch1_ovr, ch1_data} = x;
		{ch2_ovr, ch2_data} = y;
		@(posedge core_clk) #1;
		sample_valid = 1'b0;
		chk(strobe, 1'b1);
		// words hold until the next sample, the strobe stands one cycle
		@(posedge core_clk) #1;
		chk(strobe, 1'b0);
	endtask
	function automatic logic [16:0] fmt(logic [16:0] w, logic r, logic al);
		return w ^ {1'b0, {15{r & w[0]}}, 1'b0} ^ {1'b0, al ? 16'hAAAA : 16'h0000};
	endfunction
	function automatic logic [16:0] unfmt(logic [16:0] w, logic r, logic al);
		logic [16:0] u;
		u = w ^ {1'b0, al ? 16'hAAAA : 16'h0000};
		return u ^ {1'b0, {15{r & u[0]}}, 1'b0};
	endfunction
	// nap1, nap2 (masked in sleep), sleep
	function automatic logic [2:0] pexp(logic [1:0] p);
		return (p == 2'd0) ? 3'b000 : (p == 2'd1) ? 3'b010 : (p == 2'd2) ? 3'b110 : 3'b001;
	endfunction
	initial
	begin
		// about three times the expected run
		#100000;
		fails++;
		results();
	end
	initial
	begin
		{reset, sample_valid, ch1_ovr, ch2_ovr, port_style_select, ch1_data, ch2_data} = {1'b1, 36'h0};
		void'($urandom(32'h120A));
		repeat (4) @(posedge core_clk);
		#1 reset = 1'b0;
		repeat (3) @(posedge core_clk) #1;
		chk({outputs_oe, strobe, device_sleep, ch1_nap}, 4'h8);
		chk({ch1_of, ch1_out}, 17'h00000);
		cfg(7'h00, 8'h80);
		for (int p = 0; p < 4; p++)
		begin
			cfg(7'h01, {6'h00, p[1:0]});
			chk({ch1_nap & ~device_sleep, ch2_nap & ~device_sleep, device_sleep}, pexp(p[1:0]));
			rdchk(7'h01, {6'h00, p[1:0]});
			chk(device_sleep, p == 3);
		end
		cfg(7'h01, 8'h00);
		// no analog settling here, so the wake-up wait is counted in core cycles
		repeat (100) @(posedge core_clk) #1;
		chk({ch1_nap, ch2_nap, device_sleep}, 3'b000);
		rdchk(7'h7F, 8'h00);
		for (int m = 0; m < 4; m++)
		begin
			cfg(7'h04, {5'h00, m[1], m[0], 1'b0});
			for (int i = 0; i < 6; i++)
			begin
				w1 = (i == 0) ? 17'h00001 : 17'($urandom);
				w2 = (i == 0) ? 17'h1FFFE : 17'($urandom);
				sample(w1, w2);
				chk({ch1_of, ch1_out}, fmt(w1, m[0], m[1]));
				chk({ch2_of, ch2_out}, fmt(w2, m[0], m[1]));
				chk(unfmt({ch1_of, ch1_out}, m[0], m[1]), w1);
				chk(unfmt({ch2_of, ch2_out}, m[0], m[1]), w2);
			end
		end
		for (int p = 1; p <= 4; p++)
		begin
			cfg(7'h04, {2'b00, p[2:0], 3'b110});
			a = (p == 3) ? 17'h1FFFF : 17'h15555;
			for (int i = 0; i < 4; i++)
			begin
				sample(17'($urandom), 17'($urandom));
				w1 = {ch1_of, ch1_out};
				if (p < 3)
					exp = (p == 1) ? 17'h1FFFF : 17'h00000;
				else if (i == 0)
					exp = (w1 === a) ? a : ~a;
				else
					exp = ~prev;
				chk(w1, exp);
				chk({ch2_of, ch2_out}, exp);
				prev = exp;
			end
		end
		cfg(7'h01, 8'h02);
		cfg(7'h03, 8'h05);
		chk({outputs_oe, lvds_ddr_mode}, 2'b01);
		dac_host_model_i.xfer({1'b0, 7'h04, 8'h06}, 12, rd);
		rdchk(7'h04, 8'h26);
		dac_host_model_i.xfer({1'b0, 7'h04, 8'h04}, 20, rd);
		rdchk(7'h04, 8'h04);
		cfg(7'h00, 8'h80);
		rdchk(7'h04, 8'h00);
		chk({outputs_oe, device_sleep}, 2'b10);
		cfg(7'h04, 8'h02);
		rdchk(7'h04, 8'h02);
		@(posedge core_clk) #1;
		port_style_select = 1'b1;
		for (int i = 0; i < 16; i++)
		begin
			dac_host_model_i.pins(i[3:0]);
			repeat (5) @(posedge core_clk) #1;
			chk({dcs_enable, lvds_ddr_mode}, i[3:2]);
			chk({ch1_nap & ~device_sleep, ch2_nap & ~device_sleep, device_sleep}, pexp(i[1:0]));
		end
		results();
	end
endmodule
